// ---- sim/pss_props.sv ----
// Purpose: port checks of the shifter
// Assumes: a trigger shows on serial_out one edge after it is sampled
// Notes: triggers with a word waiting are skipped, as they may be dropped
`default_nettype none
module pss_props #(
    parameter int unsigned STAGES = pss_pkg::PSS_STAGES_DEF
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic shift_clock,
    input wire logic clock_enable_n,
    input wire logic clear_n,
    input wire logic parallel_select_n,
    input wire logic [STAGES-1:0] parallel_in,
    input wire logic serial_out,
    input wire logic word_valid,
    input wire logic [STAGES-1:0] word_data,
    input wire logic word_ready,
    input wire logic [pss_pkg::PSS_ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [pss_pkg::PSS_DATA_W-1:0] reg_rdata
);
    import pss_pkg::*;
    logic gate_r;
    logic trig;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gate_r <= PSS_GATE_RESET;
        end else begin
            gate_r <= shift_clock | clock_enable_n;
        end
    end
    // mirrors the gate history, so a gate high out of reset is no edge
    assign trig = (shift_clock | clock_enable_n) & ~gate_r & clear_n;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_clear; !clear_n |=> !serial_out; endproperty
    a_clear: assert property (p_clear) else $error("serial out not cleared");
    property p_hold; $changed(serial_out) && clear_n && $past(clear_n) |-> $past(trig); endproperty
    a_hold: assert property (p_hold) else $error("serial out moved untriggered");
    property p_load;
        logic v;
        (trig && !parallel_select_n && !word_valid, v = parallel_in[STAGES-1]) ##1 clear_n
            |=> serial_out == v || !clear_n;
    endproperty
    a_load: assert property (p_load) else $error("parallel load missed");
    property p_idle; !reg_rd |=> reg_rdata == '0; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_unmapped; reg_rd && reg_addr > PSS_OFS_OPCOUNT |=> reg_rdata == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_stat; reg_rd && reg_addr == PSS_OFS_STATUS |=> reg_rdata[4] == $past(serial_out); endproperty
    a_stat: assert property (p_stat) else $error("status serial bit wrong");
    property p_last; reg_rd && reg_addr == PSS_OFS_STAGES |=> reg_rdata[STAGES-1] == $past(serial_out); endproperty
    a_last: assert property (p_last) else $error("serial out not last stage");
    property p_word; word_valid && !word_ready |=> word_valid && $stable(word_data); endproperty
    a_word: assert property (p_word) else $error("word lost in stall");
    c_load: cover property (trig && !parallel_select_n);
    c_shift: cover property (trig && parallel_select_n);
    c_stall: cover property ((word_valid && !word_ready) [*3]);
endmodule : pss_props
`default_nettype wire

// ---- sim/pss_sink.sv ----
// Purpose: word sink at the stream side of the shifter
// Assumes: stall comes from the bench
// Notes: answers at once unless stalled, no random pacing to keep drops predictable
`default_nettype none
module pss_sink (
    input wire logic stall,
    output logic word_ready
);
    assign word_ready = ~stall;
endmodule : pss_sink
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: self-checking bench of the shifter
// Assumes: triggers spaced eight cycles, so stream words pop before the next
// Notes: words are matched in order against a queue the bench builds
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pss_pkg::*;
    logic clk_sys, resetn, shift_clock, clock_enable_n, clear_n, parallel_select_n, serial_in;
    logic serial_out, word_valid, word_ready, reg_wr, reg_rd, stall, stream;
    logic [7:0] parallel_in, word_data, reg_addr, m;
    logic [31:0] reg_wdata, reg_rdata, d, r;
    logic [7:0] q[$];
    int num_errors = 0;
    int checks = 0;
    int seed = 1508;
    int cnt = 0;
    int nl = 0;
    int ns = 0;
    pss_shifter i_dut (.clk_sys(clk_sys), .resetn(resetn), .shift_clock(shift_clock),
        .clock_enable_n(clock_enable_n), .clear_n(clear_n), .parallel_select_n(parallel_select_n),
        .serial_in(serial_in), .parallel_in(parallel_in), .serial_out(serial_out), .word_valid(word_valid),
        .word_data(word_data), .word_ready(word_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    pss_sink i_sink (.stall(stall), .word_ready(word_ready));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #500000;
        num_errors++;
        tally_and_finish();
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= {w, !w};
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'b00;
        #1;
        d = reg_rdata;
    endtask : bus
    // reference of one taken trigger: stages, shift count, op counts and stream queue
    function automatic void model(input logic ps, input logic si, input logic [7:0] pi);
        m = ps ? {m[6:0], si} : pi;
        cnt = ps ? cnt + 1 : 0;
        if (ps) begin
            ns++;
        end else begin
            nl++;
        end
        if (!ps || cnt == 8) begin
            cnt = 0;
            if (stream) q.push_back(m);
        end
    endfunction : model
    // either pin may act as the clock, the other then held low as enable
    task automatic trig(input logic ps, input logic si, input logic [7:0] pi, input logic alt, input logic drop);
        @(posedge clk_sys);
        {parallel_select_n, serial_in, parallel_in} <= {ps, si, pi};
        {clock_enable_n, shift_clock} <= {alt, !alt};
        @(posedge clk_sys);
        {clock_enable_n, shift_clock} <= 2'b00;
        if (!drop) begin
            model(ps, si, pi);
        end
        repeat (4) @(posedge clk_sys);
        bus(1'b0, PSS_OFS_STAGES, 32'h0);
        chk("stages", d, {24'h0, m});
        chk("serial_out", {31'h0, serial_out}, {31'h0, m[7]});
    endtask : trig
    task automatic burst(input int n);
        repeat (n) begin
            r = $random(seed);
            if (r[7:5] == 3'h0) begin
                @(posedge clk_sys);
                {clear_n, shift_clock} <= 2'b01;
                #1;
                chk("cleared", {31'h0, serial_out}, 32'h0);
                @(posedge clk_sys);
                shift_clock <= 1'b0;
                @(posedge clk_sys);
                clear_n <= 1'b1;
                m = 8'h00;
                cnt = 0;
            end
            trig(r[0], r[1], r[15:8], r[2], 1'b0);
        end
    endtask : burst
    always @(posedge clk_sys) begin
        if (resetn && word_valid && word_ready) begin
            chk("word", {24'h0, word_data}, {24'h0, (q.size() > 0) ? q.pop_front() : 8'hXX});
        end
    end
    initial begin
        {resetn, shift_clock, clock_enable_n, reg_wr, reg_rd, stall, stream, serial_in} = '0;
        {clear_n, parallel_select_n, parallel_in, reg_addr, reg_wdata, m} = {2'b11, 56'h0};
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        bus(1'b0, PSS_OFS_CTRL, 32'h0);
        chk("ctrl", d, 32'h0);
        bus(1'b0, PSS_OFS_STATUS, 32'h0);
        chk("status", d & 32'h30E0, 32'h40);
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", d, 32'h0);
        burst(30);
        @(posedge clk_sys);
        shift_clock <= 1'b1;
        // the clock rise itself is a real trigger with the pins left by the last one
        model(parallel_select_n, serial_in, parallel_in);
        @(posedge clk_sys);
        clock_enable_n <= 1'b1;
        repeat (6) begin
            @(posedge clk_sys);
            r = $random(seed);
            {shift_clock, parallel_select_n, serial_in, parallel_in} <= {~shift_clock, r[1:0], r[15:8]};
        end
        @(posedge clk_sys);
        clock_enable_n <= 1'b0;
        @(posedge clk_sys);
        shift_clock <= 1'b0;
        bus(1'b0, PSS_OFS_STAGES, 32'h0);
        chk("held", d, {24'h0, m});
        bus(1'b1, PSS_OFS_CTRL, 32'h1);
        stream = 1'b1;
        burst(20);
        stall <= 1'b1;
        trig(1'b0, 1'b0, 8'h3C, 1'b0, 1'b0);
        trig(1'b0, 1'b0, 8'hC3, 1'b1, 1'b0);
        trig(1'b0, 1'b0, 8'h5A, 1'b0, 1'b1);
        bus(1'b0, PSS_OFS_STATUS, 32'h0);
        chk("stall", d & 32'hAF, 32'hA8);
        bus(1'b1, PSS_OFS_CTRL, 32'h3);
        stall <= 1'b0;
        repeat (6) @(posedge clk_sys);
        bus(1'b0, PSS_OFS_STATUS, 32'h0);
        chk("drained", d & 32'hE0, 32'h40);
        chk("left", q.size(), 32'h0);
        bus(1'b0, PSS_OFS_OPCOUNT, 32'h0);
        chk("opcount", d, {ns[15:0], nl[15:0]});
        tally_and_finish();
    end
endmodule : tb
bind pss_shifter pss_props #(.STAGES(STAGES)) i_props (.clk_sys(clk_sys), .resetn(resetn),
    .shift_clock(shift_clock), .clock_enable_n(clock_enable_n), .clear_n(clear_n),
    .parallel_select_n(parallel_select_n), .parallel_in(parallel_in), .serial_out(serial_out),
    .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// ---- verilog/pss_pkg.sv ----
// Purpose: shared constants and types of the parallel/serial shifter
// Assumes: one clock, clk_sys at 40 MHz; register port is byte addressed, one word per register
// Notes: offsets are byte addresses, each register one aligned 32-bit word
`default_nettype none

package pss_pkg;

    // register port geometry
    localparam int unsigned PSS_ADDR_W = 8;
    localparam int unsigned PSS_DATA_W = 32;

    // register offsets
    localparam logic [PSS_ADDR_W-1:0] PSS_OFS_CTRL = 8'h00;
    localparam logic [PSS_ADDR_W-1:0] PSS_OFS_STATUS = 8'h04;
    localparam logic [PSS_ADDR_W-1:0] PSS_OFS_STAGES = 8'h08;
    localparam logic [PSS_ADDR_W-1:0] PSS_OFS_OPCOUNT = 8'h0C;

    // control fields
    localparam int unsigned PSS_CTRL_STREAM_BIT = 0;
    localparam int unsigned PSS_CTRL_STALL_CLR_BIT = 1;
    localparam logic PSS_CTRL_STREAM_RESET = 1'b0;

    // status fields
    localparam int unsigned PSS_STAT_OP_LSB = 0;
    localparam int unsigned PSS_STAT_SERIAL_BIT = 4;
    localparam int unsigned PSS_STAT_FULL_BIT = 5;
    localparam int unsigned PSS_STAT_EMPTY_BIT = 6;
    localparam int unsigned PSS_STAT_STALL_BIT = 7;
    localparam int unsigned PSS_STAT_GATE_BIT = 8;
    localparam int unsigned PSS_STAT_LEVEL_LSB = 12;

    // operation counter fields
    localparam int unsigned PSS_CNT_W = 16;
    localparam int unsigned PSS_OPCNT_LOAD_LSB = 0;
    localparam int unsigned PSS_OPCNT_SHIFT_LSB = 16;

    // gate level assumed before reset release, so a high gate at start is no edge
    localparam logic PSS_GATE_RESET = 1'b1;

    // documented defaults
    localparam int unsigned PSS_STAGES_DEF = 8;
    localparam int unsigned PSS_DEPTH_DEF = 2;

    typedef enum logic [3:0] {
        PSS_OP_IDLE  = 4'h1,
        PSS_OP_LOAD  = 4'h2,
        PSS_OP_SHIFT = 4'h4,
        PSS_OP_HOLD  = 4'h8
    } pss_op_e;

endpackage : pss_pkg

`default_nettype wire

// ---- verilog/pss_shifter.sv ----
// Purpose: eight-stage shifter with synchronous parallel or serial entry and a word stream out
// Assumes: all pins synchronous to clk_sys; shift_clock and clock_enable_n are sampled levels
// Notes: the gated clock is an edge detector on the OR of the two pins, not a real clock
//
// Behaviour
// - eight stages, parallel or serial entry chosen by active-low select, all synchronous.
// - select low at the rising edge copies the parallel byte into the stages.
// - select high at the rising edge loads the first stage from serial input.
// - on a serial entry every stage passes its old value one stage onward.
// - the last stage drives the serial output for chaining.
// - clock and active-low enable are ORed; either pin may serve as clock.
// - while enable is high the stages and serial output stay unchanged.
// - clear low forces all stages low at once, over every other input.
// - serial entry is sampled on the clock so devices can be chained.
//
// The strobed register port and the address map are this design's own decisions.
`default_nettype none

module pss_shifter #(
    parameter int unsigned STAGES = pss_pkg::PSS_STAGES_DEF,
    parameter int unsigned DEPTH = pss_pkg::PSS_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic shift_clock,
    input wire logic clock_enable_n,
    input wire logic clear_n,
    input wire logic parallel_select_n,
    input wire logic serial_in,
    input wire logic [STAGES-1:0] parallel_in,
    output logic serial_out,
    output logic word_valid,
    output logic [STAGES-1:0] word_data,
    input wire logic word_ready,
    input wire logic [pss_pkg::PSS_ADDR_W-1:0] reg_addr,
    input wire logic [pss_pkg::PSS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pss_pkg::PSS_DATA_W-1:0] reg_rdata
);
    import pss_pkg::*;

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = PW + 1;
    localparam int unsigned BW = (STAGES > 1) ? $clog2(STAGES) : 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [BW-1:0] LAST_BIT = BW'(STAGES - 1);

    typedef struct packed {
        logic gate_r;
        logic stream_en;
        logic stall;
        logic push_pend;
        pss_op_e last_op;
        logic [BW-1:0] bit_cnt;
        logic [PSS_CNT_W-1:0] loads;
        logic [PSS_CNT_W-1:0] shifts;
        logic [DEPTH-1:0][STAGES-1:0] fifo;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] level;
        logic out_valid;
        logic [STAGES-1:0] out_data;
        logic [PSS_DATA_W-1:0] rdata;
    } pss_state_s;

    pss_state_s st_r;
    pss_state_s st_nxt;

    logic [STAGES-1:0] stage_q;
    logic gate;
    logic gate_edge;
    logic active;
    logic blocked;
    logic step;
    logic load;
    logic push;
    logic pop;

    generate
        if (STAGES < 2 || STAGES > PSS_DATA_W) begin : g_bad_stages
            $error("pss_shifter: STAGES must lie between 2 and the register width");
        end
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("pss_shifter: DEPTH must be a power of two, at least 2");
        end
        if (CW + PSS_STAT_LEVEL_LSB > PSS_DATA_W) begin : g_bad_level
            $error("pss_shifter: buffer level does not fit the status word");
        end
    endgenerate

    // register read decode, unmapped offsets read as zero
    function automatic logic [PSS_DATA_W-1:0] read_word(
        input logic [PSS_ADDR_W-1:0] addr,
        input pss_state_s s,
        input logic [STAGES-1:0] q
    );
        logic [PSS_DATA_W-1:0] w;
        w = '0;
        unique case (addr)
            PSS_OFS_CTRL: begin
                w[PSS_CTRL_STREAM_BIT] = s.stream_en;
            end
            PSS_OFS_STATUS: begin
                w[PSS_STAT_OP_LSB +: 4] = s.last_op;
                w[PSS_STAT_SERIAL_BIT] = q[STAGES-1];
                w[PSS_STAT_FULL_BIT] = (s.level == DEPTH_C);
                w[PSS_STAT_EMPTY_BIT] = (s.level == '0);
                w[PSS_STAT_STALL_BIT] = s.stall;
                w[PSS_STAT_GATE_BIT] = s.gate_r;
                w[PSS_STAT_LEVEL_LSB +: CW] = s.level;
            end
            PSS_OFS_STAGES: begin
                w[STAGES-1:0] = q;
            end
            PSS_OFS_OPCOUNT: begin
                w[PSS_OPCNT_LOAD_LSB +: PSS_CNT_W] = s.loads;
                w[PSS_OPCNT_SHIFT_LSB +: PSS_CNT_W] = s.shifts;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction : read_word

    // the two pins are interchangeable: a high on either one masks the other
    assign gate = shift_clock | clock_enable_n;
    // a rising gate is the only trigger; enable held high keeps the gate high
    assign gate_edge = gate & ~st_r.gate_r;
    // a raise of enable while the clock is low shows here as an edge
    assign active = gate_edge & clear_n;
    // with streaming on, a full buffer holds the stages rather than lose a word
    assign blocked = st_r.stream_en & ((st_r.level == DEPTH_C) | st_r.push_pend);
    assign step = active & ~blocked;
    assign load = ~parallel_select_n;
    assign push = st_r.push_pend;
    assign pop = st_r.out_valid & word_ready;

    pss_stages #(
        .STAGES(STAGES)
    ) u_stages (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear_n(clear_n),
        .step(step),
        .load(load),
        .par_in(parallel_in),
        .ser_in(serial_in),
        .stage_q(stage_q)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.gate_r = gate;
        st_nxt.push_pend = 1'b0;

        // software writes first, so a stall caught in the same cycle survives the clear
        if (reg_wr && reg_addr == PSS_OFS_CTRL) begin
            st_nxt.stream_en = reg_wdata[PSS_CTRL_STREAM_BIT];
            if (reg_wdata[PSS_CTRL_STALL_CLR_BIT]) begin
                st_nxt.stall = 1'b0;
            end
        end

        if (step) begin
            if (load) begin
                st_nxt.last_op = PSS_OP_LOAD;
                st_nxt.loads = st_r.loads + PSS_CNT_W'(1);
                st_nxt.bit_cnt = '0;
                st_nxt.push_pend = st_r.stream_en;
            end else begin
                st_nxt.last_op = PSS_OP_SHIFT;
                st_nxt.shifts = st_r.shifts + PSS_CNT_W'(1);
                if (st_r.bit_cnt == LAST_BIT) begin
                    st_nxt.bit_cnt = '0;
                    st_nxt.push_pend = st_r.stream_en;
                end else begin
                    st_nxt.bit_cnt = st_r.bit_cnt + BW'(1);
                end
            end
        end else if (active) begin
            st_nxt.last_op = PSS_OP_HOLD;
            st_nxt.stall = 1'b1;
        end else if (gate_edge) begin
            st_nxt.last_op = PSS_OP_IDLE;
        end

        // clear empties the serial word in progress along with the stages
        if (!clear_n) begin
            st_nxt.bit_cnt = '0;
        end

        // the stages hold the new word one cycle after the step
        if (push) begin
            st_nxt.fifo[st_r.wr_ptr] = stage_q;
            st_nxt.wr_ptr = st_r.wr_ptr + PW'(1);
        end
        if (pop) begin
            st_nxt.rd_ptr = st_r.rd_ptr + PW'(1);
        end
        unique case ({push, pop})
            2'b10: st_nxt.level = st_r.level + CW'(1);
            2'b01: st_nxt.level = st_r.level - CW'(1);
            default: st_nxt.level = st_r.level;
        endcase
        st_nxt.out_valid = (st_nxt.level != '0);
        st_nxt.out_data = st_nxt.fifo[st_nxt.rd_ptr];

        // read data stands only in the cycle after the strobe
        st_nxt.rdata = '0;
        if (reg_rd) begin
            st_nxt.rdata = read_word(reg_addr, st_r, stage_q);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.gate_r <= PSS_GATE_RESET;
            st_r.stream_en <= PSS_CTRL_STREAM_RESET;
            st_r.last_op <= PSS_OP_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign serial_out = stage_q[STAGES-1];
    assign word_valid = st_r.out_valid;
    assign word_data = st_r.out_data;
    assign reg_rdata = st_r.rdata;

endmodule : pss_shifter

`default_nettype wire

// ---- verilog/pss_stages.sv ----
// Purpose: the register stages themselves, with parallel or serial entry
// Assumes: step is a one-cycle pulse made by the top from the gated clock edge
// Notes: clear_n acts without the clock and outranks every other input
`default_nettype none

module pss_stages #(
    parameter int unsigned STAGES = pss_pkg::PSS_STAGES_DEF
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clear_n,
    input wire logic step,
    input wire logic load,
    input wire logic [STAGES-1:0] par_in,
    input wire logic ser_in,
    output logic [STAGES-1:0] stage_q
);
    import pss_pkg::*;

    typedef struct packed {
        logic [STAGES-1:0] q;
    } pss_stage_s;

    pss_stage_s st_r;
    pss_stage_s st_nxt;

    generate
        if (STAGES < 2) begin : g_bad_stages
            $error("pss_stages: STAGES must be at least 2");
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        if (step) begin
            if (load) begin
                st_nxt.q = par_in;
            end else begin
                st_nxt.q = {st_r.q[STAGES-2:0], ser_in};
            end
        end
    end

    // clear is a pin, not a reset tree: it still only loads the constant zero
    always_ff @(posedge clk_sys or negedge resetn or negedge clear_n) begin
        if (!resetn || !clear_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stage_q = st_r.q;

endmodule : pss_stages

`default_nettype wire
